/* File: inc/tsm_pkg.sv */
// Package of constants and types for the switch mode and reset control block
// ****************************************************************************
// Operation
// - Rising start bit begins block programming
// - Programming takes two frames once enabled
// - Device clears start bit when done
// - Clearing start, or enable while running, aborts programming
// - Soft reset bit holds switching blocks
// - Upper bidir select ties upper inputs low
// ****************************************************************************
package tsm_pkg;
    // Register word indices (byte address is four times the index)
    localparam logic [3:0] TSM_IDX_MODE = 4'h1;
    localparam logic [3:0] TSM_IDX_RESET = 4'h2;
    localparam logic [3:0] TSM_IDX_CTRL = 4'h3;
    // Mode register field positions
    localparam int TSM_MODE_START_BIT = 0;
    localparam int TSM_MODE_PAT_LSB = 1;
    localparam int TSM_MODE_TXEN_BIT = 4;
    localparam int TSM_MODE_RXEN_BIT = 5;
    localparam int TSM_MODE_LOBIDIR_BIT = 6;
    localparam int TSM_MODE_UPBIDIR_BIT = 7;
    localparam int TSM_MODE_PD_BIT = 8;
    // Writable mask of the mode register (bits 15-9 read zero)
    localparam logic [15:0] TSM_MODE_MASK = 16'h01FF;
    // Soft reset bit position and writable mask
    localparam int TSM_RST_SW_BIT = 1;
    localparam logic [15:0] TSM_RST_MASK = 16'h0002;
    // Control register: block program enable
    localparam int TSM_CTRL_BPE_BIT = 0;
    localparam logic [15:0] TSM_CTRL_MASK = 16'h0001;
    // Reset values
    localparam logic [15:0] TSM_MODE_RST = 16'h0000;
    localparam logic [15:0] TSM_RST_RST = 16'h0000;
    localparam logic [15:0] TSM_CTRL_RST = 16'h0000;
    // Frames needed to finish block programming
    localparam logic [1:0] TSM_PROG_FRAMES = 2'h2;
    // Block programming states, Gray from TSM_IDLE through TSM_ARM to TSM_RUN; the return from TSM_RUN to TSM_IDLE flips both bits
    typedef enum logic [1:0] {
        TSM_IDLE = 2'b00,
        TSM_ARM = 2'b01,
        TSM_RUN = 2'b11
    } tsm_state_t;
    // Decoded mode settings handed to the datapath
    typedef struct packed {
        logic upper_bidir_select;
        logic lower_bidir_select;
        logic rx_error_test_global_enable;
        logic tx_error_test_global_enable;
        logic stream_pulldown_enable;
    } tsm_mode_t;
endpackage

/* File: hdl/tsm_sync.sv */
// Three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module tsm_sync
    import tsm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Async level in, filtered level out
    input wire logic din,
    output logic dout
);
    // Stage registers
    logic [2:0] stg_r;
    logic [2:0] stg_nxt;
    logic out_r;
    logic out_nxt;

    // Shift and update output when the two later stages agree
    always_comb
    begin
        stg_nxt = {stg_r[1:0], din};
        out_nxt = out_r;
        if (stg_r[2] == stg_r[1])
        begin
            out_nxt = stg_r[2];
        end
    end

    // Registers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stg_r <= 3'h0;
            out_r <= 1'b0;
        end
        else
        begin
            stg_r <= stg_nxt;
            out_r <= out_nxt;
        end
    end

    assign dout = out_r;
endmodule // tsm_sync

/* File: hdl/tsm_ctrl.sv */
// Mode selection and software reset register bank for the switch
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
module tsm_ctrl
    import tsm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Frame pulse from the timing block (asynchronous)
    input wire logic frame_pulse,
    // Connection memory fill port
    output logic cm_fill_we,
    output logic [15:0] cm_fill_data,
    output logic prog_busy,
    // Switch control outputs
    output logic switch_soft_reset,
    output tsm_mode_t mode_out,
    // Per-stream test enables in, gated enables out
    input wire logic [31:0] rx_test_en_in,
    input wire logic [31:0] tx_test_en_in,
    output logic [31:0] rx_test_en_out,
    output logic [31:0] tx_test_en_out,
    // Upper stream input gating
    input wire logic [15:0] upper_stream_in,
    output logic [15:0] upper_stream_gated,
    output logic [15:0] upper_stream_oe_n,
    input wire logic [15:0] upper_out_drive_n
);
    // ************************************************************************
    // Bus and register state
    // ************************************************************************
    logic [15:0] mode_r;
    logic [15:0] mode_nxt;
    logic [15:0] rst_r;
    logic [15:0] rst_nxt;
    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    // Programming state
    tsm_state_t st_r;
    tsm_state_t st_nxt;
    logic [1:0] frm_r;
    logic [1:0] frm_nxt;
    logic fp_prev_r;
    logic fp_prev_nxt;
    logic fill_r;
    logic fill_nxt;
    // Synchronised frame pulse and its edge
    logic fp_s;
    logic fp_rise;
    logic wr_mode;
    logic [15:0] wmask;
    logic done;

    // Frame pulse synchroniser
    tsm_sync u_fp_sync (
        .clk(clk),
        .arst_n(arst_n),
        .din(frame_pulse),
        .dout(fp_s)
    );

    assign fp_rise = fp_s & ~fp_prev_r;
    // Byte lanes 0 and 1 carry the 16-bit register
    assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wr_mode = avs_write & ~ack_r & (avs_address == TSM_IDX_MODE);
    // Completion: second frame edge while running
    assign done = (st_r == TSM_RUN) & fp_rise & (frm_r == TSM_PROG_FRAMES - 2'h1);

    // ************************************************************************
    // Register next values and bus answer
    // ************************************************************************
    always_comb
    begin
        mode_nxt = mode_r;
        rst_nxt = rst_r;
        ctrl_nxt = ctrl_r;
        rdata_nxt = rdata_r;
        // One wait cycle, then answer
        ack_nxt = (avs_read | avs_write) & ~ack_r;
        if (avs_write & ~ack_r)
        begin
            case (avs_address)
                TSM_IDX_MODE: mode_nxt = ((mode_r & ~wmask) | (avs_writedata[15:0] & wmask)) & TSM_MODE_MASK;
                // Reserved reset bits are dropped, not stored
                TSM_IDX_RESET: rst_nxt = ((rst_r & ~wmask) | (avs_writedata[15:0] & wmask)) & TSM_RST_MASK;
                TSM_IDX_CTRL: ctrl_nxt = ((ctrl_r & ~wmask) | (avs_writedata[15:0] & wmask)) & TSM_CTRL_MASK;
                default: ;
            endcase
        end
        // Hardware clear of start bit on completion, wins over a same-cycle rewrite
        if (done)
        begin
            mode_nxt[TSM_MODE_START_BIT] = 1'b0;
        end
        if (avs_read & ~ack_r)
        begin
            case (avs_address)
                TSM_IDX_MODE: rdata_nxt = {16'h0000, mode_r};
                TSM_IDX_RESET: rdata_nxt = {16'h0000, rst_r};
                TSM_IDX_CTRL: rdata_nxt = {16'h0000, ctrl_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************************
    // Block programming sequencer
    // ************************************************************************
    always_comb
    begin
        st_nxt = st_r;
        frm_nxt = frm_r;
        fill_nxt = 1'b0;
        fp_prev_nxt = fp_s;
        case (st_r)
            TSM_IDLE:
            begin
                // Start on a zero to one write of the start bit
                if (wr_mode & avs_byteenable[0] & ~mode_r[TSM_MODE_START_BIT]
                    & avs_writedata[TSM_MODE_START_BIT])
                begin
                    st_nxt = TSM_ARM;
                end
            end
            TSM_ARM:
            begin
                frm_nxt = 2'h0;
                if (~mode_r[TSM_MODE_START_BIT])
                begin
                    st_nxt = TSM_IDLE;
                end
                else if (ctrl_r[TSM_CTRL_BPE_BIT] & fp_rise)
                begin
                    st_nxt = TSM_RUN;
                end
            end
            TSM_RUN:
            begin
                if (~mode_r[TSM_MODE_START_BIT] | ~ctrl_r[TSM_CTRL_BPE_BIT])
                begin
                    st_nxt = TSM_IDLE;
                end
                else if (done)
                begin
                    fill_nxt = 1'b1;
                    st_nxt = TSM_IDLE;
                end
                else if (fp_rise)
                begin
                    frm_nxt = frm_r + 2'h1;
                end
            end
            default: st_nxt = TSM_IDLE;
        endcase
    end

    // Registers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode_r <= TSM_MODE_RST;
            rst_r <= TSM_RST_RST;
            ctrl_r <= TSM_CTRL_RST;
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            st_r <= TSM_IDLE;
            frm_r <= 2'h0;
            fp_prev_r <= 1'b0;
            fill_r <= 1'b0;
        end
        else
        begin
            mode_r <= mode_nxt;
            rst_r <= rst_nxt;
            ctrl_r <= ctrl_nxt;
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
            st_r <= st_nxt;
            frm_r <= frm_nxt;
            fp_prev_r <= fp_prev_nxt;
            fill_r <= fill_nxt;
        end
    end

    // ************************************************************************
    // Outputs
    // ************************************************************************
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign avs_readdata = rdata_r;
    // Pattern in low three bits, upper bits cleared
    assign cm_fill_we = fill_r;
    assign cm_fill_data = {13'h0000, mode_r[TSM_MODE_PAT_LSB +: 3]};
    assign prog_busy = (st_r != TSM_IDLE);
    assign switch_soft_reset = rst_r[TSM_RST_SW_BIT];
    assign mode_out.upper_bidir_select = mode_r[TSM_MODE_UPBIDIR_BIT];
    assign mode_out.lower_bidir_select = mode_r[TSM_MODE_LOBIDIR_BIT];
    assign mode_out.rx_error_test_global_enable = mode_r[TSM_MODE_RXEN_BIT];
    assign mode_out.tx_error_test_global_enable = mode_r[TSM_MODE_TXEN_BIT];
    assign mode_out.stream_pulldown_enable = mode_r[TSM_MODE_PD_BIT];
    // Global gates over per-stream test enables
    assign rx_test_en_out = rx_test_en_in & {32{mode_r[TSM_MODE_RXEN_BIT]}};
    assign tx_test_en_out = tx_test_en_in & {32{mode_r[TSM_MODE_TXEN_BIT]}};
    // Upper inputs low and outputs bidirectional when selected
    assign upper_stream_gated = upper_stream_in & {16{~mode_r[TSM_MODE_UPBIDIR_BIT]}};
    // Plain outputs always drive; bidirectional pins drive only when asked
    assign upper_stream_oe_n = upper_out_drive_n & {16{mode_r[TSM_MODE_UPBIDIR_BIT]}};

    // ************************************************************************
    // Checks
    // ************************************************************************
    soft_reset_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
        (avs_write && !ack_r && avs_address == TSM_IDX_RESET && avs_byteenable[0])
        |=> switch_soft_reset == $past(avs_writedata[TSM_RST_SW_BIT])) else $error("soft reset mismatch");
    start_arms_a: assert property (@(posedge clk) disable iff (!arst_n)
        (st_r == TSM_IDLE && wr_mode && avs_byteenable[0] && !mode_r[0] && avs_writedata[0])
        |=> st_r == TSM_ARM) else $error("start not armed");
    fill_clears_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(fill_r) |-> !mode_r[TSM_MODE_START_BIT]) else $error("start not cleared");
    abort_stops_a: assert property (@(posedge clk) disable iff (!arst_n)
        (st_r == TSM_RUN && !ctrl_r[0]) |=> st_r == TSM_IDLE && !fill_r) else $error("abort ignored");
    fill_pattern_a: assert property (@(posedge clk) disable iff (!arst_n)
        fill_r |-> cm_fill_data[15:3] == 13'h0000) else $error("fill upper bits set");
    rx_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
        !mode_r[TSM_MODE_RXEN_BIT] |-> rx_test_en_out == 32'h0000_0000) else $error("rx test not gated");
    upper_tie_a: assert property (@(posedge clk) disable iff (!arst_n)
        mode_r[TSM_MODE_UPBIDIR_BIT] |-> upper_stream_gated == 16'h0000) else $error("upper input not tied");
    upper_drive_a: assert property (@(posedge clk) disable iff (!arst_n)
        !mode_r[TSM_MODE_UPBIDIR_BIT] |-> upper_stream_oe_n == 16'h0000) else $error("upper output not driven");
    two_frames_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(fill_r) |-> $past(frm_r) == 2'h1) else $error("fill before two frames");
endmodule // tsm_ctrl

/* File: verif/tsm_host.sv */
// Host processor model driving the Avalon-MM register port
`timescale 1ns/1ps
module tsm_host
    import tsm_pkg::*;
(
    // Clock
    input wire logic clk,
    // Avalon-MM master side
    output logic [3:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    // Bus idle at time zero
    initial
    begin
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
    end
    // Hold request until waitrequest is seen low at a rising edge, take data there
    task automatic wait_ack(output logic [31:0] rdat);
        begin
            do
            begin
                @(posedge clk);
            end
            while (avs_waitrequest !== 1'b0);
            rdat = avs_readdata;
        end
    endtask
    // Whole 16-bit word in one access, pattern and start together
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [31:0] junk;
        begin
            @(posedge clk);
            avs_address <= a;
            avs_writedata <= {16'h0, d};
            avs_byteenable <= 4'h3;
            avs_write <= 1'b1;
            wait_ack(junk);
            avs_write <= 1'b0;
            avs_writedata <= ~{16'h0, d};
            avs_byteenable <= 4'h0;
        end
    endtask
    // Read one register word
    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        begin
            @(posedge clk);
            avs_address <= a;
            avs_byteenable <= 4'h3;
            avs_read <= 1'b1;
            wait_ack(q);
            avs_read <= 1'b0;
            avs_byteenable <= 4'h0;
        end
    endtask
endmodule // tsm_host

/* File: verif/tb_tsm_ctrl.sv */
// Self-checking testbench for the switch mode and reset register bank
`timescale 1ns/1ps
module tb_tsm_ctrl;
    import tsm_pkg::*;
    // Clock, reset and design signals
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic frame_pulse = 1'b0;
    logic cm_fill_we, prog_busy, switch_soft_reset;
    logic [15:0] cm_fill_data, upper_stream_gated, upper_stream_oe_n;
    logic [15:0] upper_stream_in = 16'hBEEF;
    logic [15:0] upper_out_drive_n = 16'h3C5A;
    tsm_mode_t mode_out;
    logic [31:0] rx_test_en_in = 32'hA5A5_0F0F;
    logic [31:0] tx_test_en_in = 32'h5A5A_F0F0;
    logic [31:0] rx_test_en_out, tx_test_en_out, q;
    int mismatches = 0;
    int num_checks = 0;
    int fills = 0;
    logic [15:0] fill_val = 16'h0;
    // Design and host model
    tsm_ctrl dut (.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .frame_pulse(frame_pulse),
        .cm_fill_we(cm_fill_we), .cm_fill_data(cm_fill_data), .prog_busy(prog_busy),
        .switch_soft_reset(switch_soft_reset), .mode_out(mode_out), .rx_test_en_in(rx_test_en_in),
        .tx_test_en_in(tx_test_en_in), .rx_test_en_out(rx_test_en_out), .tx_test_en_out(tx_test_en_out),
        .upper_stream_in(upper_stream_in), .upper_stream_gated(upper_stream_gated),
        .upper_stream_oe_n(upper_stream_oe_n), .upper_out_drive_n(upper_out_drive_n));
    tsm_host host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    // 40 MHz clock
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    // Count fill pulses and keep the last fill word
    always @(posedge clk)
    begin
        if (cm_fill_we === 1'b1)
        begin
            fills <= fills + 1;
            fill_val <= cm_fill_data;
        end
    end
    // Compare and report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            num_checks++;
            if (seen !== exp)
            begin
                mismatches++;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // One frame start, then let the synchroniser catch up
    task automatic frame();
        begin
            @(posedge clk);
            frame_pulse <= 1'b1;
            repeat (3) @(posedge clk);
            frame_pulse <= 1'b0;
            repeat (10) @(posedge clk);
        end
    endtask
    // Verdict and end of run
    task automatic summarize();
        begin
            if (mismatches == 0 && num_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // Watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        summarize();
    end
    // Test sequence
    initial
    begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        // Reset values, unmapped place ignored and read zero
        for (int i = 0; i < 4; i++)
        begin
            host.rd(i[3:0], q);
            chk(q, 32'h0);
        end
        host.wr(4'h5, 16'hFFFF);
        host.rd(4'h5, q);
        chk(q, 32'h0);
        // All mode settings on, reserved bits read zero
        host.wr(TSM_IDX_MODE, 16'hFFFE);
        host.rd(TSM_IDX_MODE, q);
        chk(q, 32'h0000_01FE);
        chk({27'h0, mode_out}, 32'h1F);
        chk(rx_test_en_out, rx_test_en_in);
        chk(tx_test_en_out, tx_test_en_in);
        chk({16'h0, upper_stream_gated}, 32'h0);
        chk({16'h0, upper_stream_oe_n}, {16'h0, upper_out_drive_n});
        host.wr(TSM_IDX_MODE, 16'h0000);
        chk(rx_test_en_out, 32'h0);
        chk(tx_test_en_out, 32'h0);
        chk({16'h0, upper_stream_gated}, 32'h0000_BEEF);
        chk({16'h0, upper_stream_oe_n}, 32'h0);
        // Software reset bit, reserved bits written zero
        host.wr(TSM_IDX_RESET, 16'h0002);
        chk({31'h0, switch_soft_reset}, 32'h1);
        host.rd(TSM_IDX_RESET, q);
        chk(q, 32'h2);
        host.wr(TSM_IDX_RESET, 16'h0000);
        chk({31'h0, switch_soft_reset}, 32'h0);
        // Block program: pattern 5, one frame edge to begin, then two full frames
        host.wr(TSM_IDX_CTRL, 16'h0001);
        host.wr(TSM_IDX_MODE, 16'h000B);
        chk({31'h0, prog_busy}, 32'h1);
        frame();
        frame();
        host.rd(TSM_IDX_MODE, q);
        chk(q, 32'h0000_000B);
        chk(fills, 0);
        chk({31'h0, prog_busy}, 32'h1);
        frame();
        host.rd(TSM_IDX_MODE, q);
        chk(q, 32'h0000_000A);
        chk(fills, 1);
        chk({16'h0, fill_val}, 32'h0000_0005);
        chk({31'h0, prog_busy}, 32'h0);
        // Abort by clearing the start bit
        host.wr(TSM_IDX_MODE, 16'h0006);
        host.wr(TSM_IDX_MODE, 16'h0007);
        frame();
        host.wr(TSM_IDX_MODE, 16'h0006);
        frame();
        frame();
        chk(fills, 1);
        chk({31'h0, prog_busy}, 32'h0);
        // Abort by clearing the enable bit
        host.wr(TSM_IDX_MODE, 16'h0007);
        frame();
        host.wr(TSM_IDX_CTRL, 16'h0000);
        frame();
        frame();
        chk(fills, 1);
        chk({31'h0, prog_busy}, 32'h0);
        summarize();
    end
endmodule // tb_tsm_ctrl
